/* File: hdl/interval_timer_pkg.sv */
/*
  constants, register map and state type of the secondary update-interval timer.
  assumes a single 100 MHz clock and a synchronous register port.
*/
package interval_timer_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RELOAD_FIRST = 4'h1;
  localparam logic [3:0] ADDR_RELOAD_SECOND = 4'h2;
  localparam logic [3:0] ADDR_STROBE = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CTRL = 4'h5;
  localparam logic [3:0] ADDR_EVT_MASK = 4'h6;
  localparam logic [3:0] ADDR_EVT_STATUS = 4'h7;
  // control register fields
  localparam int CTRL_ARM = 0;
  localparam int CTRL_PAUSE = 1;
  localparam int CTRL_EDGE = 2;
  localparam int CTRL_FIRST = 3;
  localparam int CTRL_HW_EN = 4;
  localparam int CTRL_HW_POL = 5;
  localparam int CTRL_HW_MODE = 6;
  localparam int CTRL_SRC_LSB = 8;
  localparam int CTRL_GSEL_LSB = 16;
  localparam int CTRL_W = 20;
  localparam logic [19:0] CTRL_RESET = 20'h00000;
  // strobe register fields
  localparam int STB_PRELOAD = 0;
  localparam int STB_SWAP = 1;
  localparam int STB_TC_CLR = 2;
  localparam int STB_LATE_CLR = 3;
  // interrupt control fields
  localparam int IRQ_TC_EN = 0;
  localparam int IRQ_GRP_EN = 1;
  localparam int IRQ_LINE_LSB = 2;
  localparam int IRQ_W = 5;
  localparam logic [4:0] IRQ_RESET = 5'h00;
  // event bits, shared by mask and sticky status
  localparam int EVT_TC = 0;
  localparam int EVT_LATE = 1;
  localparam int EVT_W = 2;
  // clock source codes
  localparam logic [4:0] SRC_PRIMARY = 5'h00;
  localparam logic [4:0] SRC_PFI_FIRST = 5'h01;
  localparam logic [4:0] SRC_TRIG_FIRST = 5'h0b;
  localparam logic [4:0] SRC_GC_FIRST = 5'h12;
  localparam logic [4:0] SRC_SECOND_TB = 5'h14;
  localparam int SRC_COUNT = 21;
  localparam int PFI_N = 10;
  localparam int TRIG_N = 7;
  localparam int LINE_N = 8;
  localparam int GSEL_W = 4;
  // gray-coded along disarmed -> counting -> paused
  typedef enum logic [1:0] {
    ST_DISARMED = 2'b00,
    ST_COUNTING = 2'b01,
    ST_PAUSED = 2'b11
  } timer_state_t;
endpackage : interval_timer_pkg

/* File: hdl/secondary_interval_timer.sv */
/*
  secondary update-interval timer: selectable clock source and edge,
  dual reload registers, pause gates, terminal-count and late-service flags.
  assumes all inputs synchronous to clock and a one-cycle-strobe register master.
*/
// Notes on behaviour
// - pause bit one suspends, zero resumes
// - count only while no gate pauses
// - hardware gate enable, select, polarity, mode
// - clock select codes zero through twenty
// - edge zero rising, one falling
// - two reload registers, swap at terminal
// - arm starts timing, disarm stops
// - terminal flag with enable and clear
// - group line select, group enable gates
// - late service detected and readable
// - late clear strobe clears flag
// - indicator shows next reload register
// - no multi-device synchronisation offered
`timescale 1ns/1ps
module secondary_interval_timer
  import interval_timer_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [DATA_W-1:0] rdData,
  input wire logic primaryTimebase,
  input wire logic [PFI_N-1:0] functionInputs,
  input wire logic [TRIG_N-1:0] backplaneTrig,
  input wire logic [1:0] generalTerminal,
  input wire logic secondTimebase,
  output logic updatePulse,
  output logic [LINE_N-1:0] groupLines,
  output logic irq
);
  timer_state_t state_reg, state_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [CNT_W-1:0] reloadA_reg, reloadA_next, reloadB_reg, reloadB_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic nextSel_reg, nextSel_next, swap_reg, swap_next;
  logic tcFlag_reg, tcFlag_next, late_reg, late_next;
  logic [IRQ_W-1:0] irqCtrl_reg, irqCtrl_next;
  logic [EVT_W-1:0] mask_reg, mask_next, evt_reg, evt_next;
  logic srcPrev_reg, gatePrev_reg, gateTog_reg, gateTog_next;
  logic update_reg;
  logic [DATA_W-1:0] rdData_reg, rdData_next;

  logic [SRC_COUNT-1:0] srcVec;
  logic [4:0] srcSel;
  logic srcNow, tick, gateLevel, hwPause, running, tcEvent, useSel;
  logic wrCtrl, wrStb, tcClr, lateClr, disarmed;

  // no cross-device sync; align through shared source pins
  assign srcVec = {secondTimebase, generalTerminal, backplaneTrig, functionInputs,
                   primaryTimebase};
  assign srcSel = ctrl_reg[CTRL_SRC_LSB +: 5];
  assign srcNow = (srcSel <= SRC_SECOND_TB) ? srcVec[srcSel] : 1'b0;
  assign tick = ctrl_reg[CTRL_EDGE] ? (srcPrev_reg & ~srcNow) : (~srcPrev_reg & srcNow);
  // gate select beyond the function inputs reads as idle low
  assign gateLevel = ((ctrl_reg[CTRL_GSEL_LSB +: GSEL_W] < GSEL_W'(PFI_N)) ?
                      functionInputs[ctrl_reg[CTRL_GSEL_LSB +: GSEL_W]] : 1'b0)
                     ^ ctrl_reg[CTRL_HW_POL];
  // level mode pauses while gate low, toggle mode flips on each rising gate
  assign hwPause = ctrl_reg[CTRL_HW_EN] &
                   (ctrl_reg[CTRL_HW_MODE] ? gateTog_reg : ~gateLevel);
  // both gates must allow counting
  // arm gates ticks too, so no terminal slips out while the disarm settles
  assign running = (state_reg == ST_COUNTING) && ctrl_reg[CTRL_ARM] &&
                   !ctrl_reg[CTRL_PAUSE] && !hwPause;
  assign tcEvent = running && tick && (count_reg == '0);
  // swap chooses the idle register at terminal count
  assign useSel = swap_reg ? ~nextSel_reg : nextSel_reg;
  assign wrCtrl = wrStrobe && (addr == ADDR_CTRL);
  assign wrStb = wrStrobe && (addr == ADDR_STROBE);
  assign tcClr = wrStb && wrData[STB_TC_CLR];
  assign lateClr = wrStb && wrData[STB_LATE_CLR];
  assign disarmed = (state_reg == ST_DISARMED);

  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    reloadA_next = reloadA_reg;
    reloadB_next = reloadB_reg;
    count_next = count_reg;
    nextSel_next = nextSel_reg;
    swap_next = swap_reg;
    tcFlag_next = tcFlag_reg;
    late_next = late_reg;
    irqCtrl_next = irqCtrl_reg;
    mask_next = mask_reg;
    evt_next = evt_reg;
    gateTog_next = gateTog_reg;
    rdData_next = '0;
    if (gateLevel && !gatePrev_reg) begin
      gateTog_next = ~gateTog_reg;
    end
    if (!ctrl_reg[CTRL_HW_EN]) begin
      gateTog_next = 1'b0;
    end
    if (wrCtrl) begin
      ctrl_next = wrData[CTRL_W-1:0];
      // initial reload choice is frozen while armed
      if (!disarmed) begin
        ctrl_next[CTRL_FIRST] = ctrl_reg[CTRL_FIRST];
      end
    end
    if (wrStrobe && addr == ADDR_RELOAD_FIRST) begin
      reloadA_next = wrData[CNT_W-1:0];
    end
    if (wrStrobe && addr == ADDR_RELOAD_SECOND) begin
      reloadB_next = wrData[CNT_W-1:0];
    end
    if (wrStrobe && addr == ADDR_IRQ_CTRL) begin
      irqCtrl_next = wrData[IRQ_W-1:0];
    end
    if (wrStrobe && addr == ADDR_EVT_MASK) begin
      mask_next = wrData[EVT_W-1:0];
    end
    // preload takes the chosen first register while disarmed
    if (wrStb && wrData[STB_PRELOAD] && disarmed) begin
      count_next = ctrl_reg[CTRL_FIRST] ? reloadB_reg : reloadA_reg;
      nextSel_next = ctrl_reg[CTRL_FIRST];
      swap_next = 1'b0;
    end
    if (wrStb && wrData[STB_SWAP]) begin
      swap_next = 1'b1;
    end
    if (running && tick) begin
      count_next = count_reg - CNT_W'(1);
    end
    // terminal count reloads and points the indicator at the register loaded
    if (tcEvent) begin
      count_next = useSel ? reloadB_reg : reloadA_reg;
      nextSel_next = useSel;
      swap_next = 1'b0;
    end
    // arm bit drives the state machine
    case (state_reg)
      ST_DISARMED: begin
        if (ctrl_reg[CTRL_ARM]) begin
          state_next = ST_COUNTING;
        end
      end
      ST_COUNTING: begin
        if (!ctrl_reg[CTRL_ARM]) begin
          state_next = ST_DISARMED;
        end else if (ctrl_reg[CTRL_PAUSE] || hwPause) begin
          state_next = ST_PAUSED;
        end
      end
      ST_PAUSED: begin
        if (!ctrl_reg[CTRL_ARM]) begin
          state_next = ST_DISARMED;
        end else if (!ctrl_reg[CTRL_PAUSE] && !hwPause) begin
          state_next = ST_COUNTING;
        end
      end
      default: begin
        state_next = ST_DISARMED;
      end
    endcase
    // set wins over the clear strobe
    if (tcClr) begin
      tcFlag_next = 1'b0;
    end
    if (tcEvent) begin
      tcFlag_next = 1'b1;
    end
    // confirm strobe clears the late flag
    if (lateClr) begin
      late_next = 1'b0;
    end
    // an ack in the same cycle as the second terminal still counts
    if (tcEvent && tcFlag_reg && !tcClr) begin
      late_next = 1'b1;
    end
    if (rdStrobe) begin
      case (addr)
        ADDR_CTRL: rdData_next = DATA_W'(ctrl_reg);
        ADDR_RELOAD_FIRST: rdData_next = DATA_W'(reloadA_reg);
        ADDR_RELOAD_SECOND: rdData_next = DATA_W'(reloadB_reg);
        // flags, indicator and state for software
        ADDR_STATUS: rdData_next = DATA_W'({count_reg, 11'h000, state_reg, nextSel_reg,
                                            late_reg, tcFlag_reg});
        ADDR_IRQ_CTRL: rdData_next = DATA_W'(irqCtrl_reg);
        ADDR_EVT_MASK: rdData_next = DATA_W'(mask_reg);
        ADDR_EVT_STATUS: rdData_next = DATA_W'(evt_reg);
        default: rdData_next = '0;
      endcase
      if (addr == ADDR_EVT_STATUS) begin
        evt_next = '0;
      end
    end
    // sticky events outlive a read in the same cycle
    if (tcEvent) begin
      evt_next[EVT_TC] = 1'b1;
    end
    if (tcEvent && tcFlag_reg && !tcClr) begin
      evt_next[EVT_LATE] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_DISARMED;
      ctrl_reg <= CTRL_RESET;
      reloadA_reg <= '0;
      reloadB_reg <= '0;
      count_reg <= '0;
      nextSel_reg <= 1'b0;
      swap_reg <= 1'b0;
      tcFlag_reg <= 1'b0;
      late_reg <= 1'b0;
      irqCtrl_reg <= IRQ_RESET;
      mask_reg <= '0;
      evt_reg <= '0;
      srcPrev_reg <= 1'b0;
      gatePrev_reg <= 1'b0;
      gateTog_reg <= 1'b0;
      update_reg <= 1'b0;
      rdData_reg <= '0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      reloadA_reg <= reloadA_next;
      reloadB_reg <= reloadB_next;
      count_reg <= count_next;
      nextSel_reg <= nextSel_next;
      swap_reg <= swap_next;
      tcFlag_reg <= tcFlag_next;
      late_reg <= late_next;
      irqCtrl_reg <= irqCtrl_next;
      mask_reg <= mask_next;
      evt_reg <= evt_next;
      srcPrev_reg <= srcNow;
      gatePrev_reg <= gateLevel;
      gateTog_reg <= gateTog_next;
      update_reg <= tcEvent;
      rdData_reg <= rdData_next;
    end
  end

  assign rdData = rdData_reg;
  assign updatePulse = update_reg;
  // group line only while group and source enabled
  assign groupLines = (irqCtrl_reg[IRQ_GRP_EN] && irqCtrl_reg[IRQ_TC_EN] && tcFlag_reg) ?
                      LINE_N'(1) << irqCtrl_reg[IRQ_LINE_LSB +: 3] : '0;
  assign irq = |(evt_reg & mask_reg);

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  pause_hold_a: assert property ((state_reg == ST_PAUSED) |=> $stable(count_reg))
    else $error("count moved while paused");
  gate_block_a: assert property ((!disarmed && hwPause) |=> !update_reg)
    else $error("update while hardware gate paused");
  hw_off_a: assert property ((state_reg == ST_COUNTING && ctrl_reg[CTRL_ARM]
    && !ctrl_reg[CTRL_HW_EN] && !ctrl_reg[CTRL_PAUSE] && tick && count_reg != '0)
    |=> count_reg == $past(count_reg) - CNT_W'(1))
    else $error("counter stalled with gates off");
  fall_tick_a: assert property ((running && ctrl_reg[CTRL_EDGE] && $fell(srcNow)
    && count_reg != '0) |=> count_reg == $past(count_reg) - CNT_W'(1))
    else $error("falling edge not counted");
  swap_flip_a: assert property ((tcEvent && swap_reg) |=> nextSel_reg != $past(nextSel_reg))
    else $error("swap not taken at terminal");
  disarm_stop_a: assert property ((!ctrl_reg[CTRL_ARM]) [*2] |-> !updatePulse)
    else $error("update while disarmed");
  tc_flag_a: assert property (tcEvent |=> tcFlag_reg && update_reg)
    else $error("terminal flag not set");
  line_route_a: assert property ((groupLines != '0) |-> irqCtrl_reg[IRQ_GRP_EN]
    && $onehot(groupLines))
    else $error("group line misrouted");
  late_clear_a: assert property ((lateClr && !tcEvent) |=> !late_reg)
    else $error("late flag not cleared");
  preload_sel_a: assert property ((wrStb && wrData[STB_PRELOAD] && disarmed)
    |=> nextSel_reg == $past(ctrl_reg[CTRL_FIRST]))
    else $error("indicator wrong after preload");
  late_set_a: assert property ((tcEvent && tcFlag_reg && !tcClr) |=> late_reg
    && evt_reg[EVT_LATE])
    else $error("late service missed");
  late_read_a: assert property ((rdStrobe && addr == ADDR_STATUS)
    |=> rdData[1] == $past(late_reg))
    else $error("late flag not readable");
  line_sel_a: assert property ((irqCtrl_reg[IRQ_GRP_EN] && irqCtrl_reg[IRQ_TC_EN]
    && tcFlag_reg) |-> groupLines[irqCtrl_reg[IRQ_LINE_LSB +: 3]])
    else $error("selected group line not raised");
  reload_val_a: assert property (tcEvent |=> count_reg ==
    (nextSel_reg ? $past(reloadB_reg) : $past(reloadA_reg)))
    else $error("wrong reload value");
endmodule : secondary_interval_timer

/* File: test/tb_secondary_interval_timer.sv */
/*
  self-checking bench for the secondary update-interval timer.
  assumes the bench drives bus, clock sources and gate inputs directly.
*/
`timescale 1ns/1ps
module tb_secondary_interval_timer
  import interval_timer_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wrData = '0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic rdPend = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic [20:0] srcVec = '0;
  logic updatePulse;
  logic irq;
  logic [LINE_N-1:0] groupLines;
  logic [31:0] seed = 32'h1ab3a65b;
  logic [15:0] r;
  logic [15:0] s;
  logic [3:0] g;
  logic [2:0] ln;
  logic [DATA_W-1:0] expQ[$];
  int miscompares = 0;
  int compares = 0;
  int upd = 0;
  int cyc = 0;

  always #5 clock = ~clock;

  secondary_interval_timer i_dut (
    .clock(clock), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .primaryTimebase(srcVec[0]), .functionInputs(srcVec[10:1]),
    .backplaneTrig(srcVec[17:11]), .generalTerminal(srcVec[19:18]),
    .secondTimebase(srcVec[20]), .updatePulse(updatePulse),
    .groupLines(groupLines), .irq(irq)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function automatic logic [31:0] stat(input logic [15:0] n, input logic [4:0] f);
    return {n, 11'h000, f};
  endfunction : stat

  function automatic logic [31:0] ctl(input logic [4:0] c, input logic [7:0] b,
                                      input logic [3:0] gs);
    return {12'h000, gs, 3'h0, c, b};
  endfunction : ctl

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // the #1 lets the edge's register updates land before port checks
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1;
  endtask : rd

  task automatic src(input int c, input logic v);
    repeat (3) @(posedge clock);
    srcVec[c] <= v;
    repeat (3) @(posedge clock);
  endtask : src

  task automatic pulse(input int c, input int n);
    repeat (n) begin
      src(c, 1'b1);
      src(c, 1'b0);
    end
  endtask : pulse

  // read data stand only in the cycle after the strobe, zero elsewhere
  always @(posedge clock) begin
    rdPend <= rdStrobe;
    cyc++;
    if (updatePulse === 1'b1) upd++;
    if (rdPend) chk(rdData, expQ.pop_front());
    else if (!rst) chk(rdData, 32'h0);
    if (cyc == 5000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_IRQ_CTRL, 32'h0);
    rd(4'h9, 32'h0);
    seed = lfsr(seed);
    r = 16'h1 + seed[1:0];
    seed = lfsr(seed);
    s = 16'h3 + seed[1:0];
    seed = lfsr(seed);
    g = seed[3:0] % 4'ha;
    ln = seed[6:4];
    wr(ADDR_RELOAD_FIRST, {16'h0, r});
    wr(ADDR_RELOAD_SECOND, {16'h0, s});
    rd(ADDR_RELOAD_SECOND, {16'h0, s});
    // every source code, edge alternating; read between rise and fall
    for (int c = 0; c < SRC_COUNT; c++) begin
      wr(ADDR_CTRL, ctl(c[4:0], {5'h0, c[0], 2'h0}, 4'h0));
      wr(ADDR_STROBE, 32'h1);
      rd(ADDR_STATUS, stat(r, 5'h00));
      wr(ADDR_CTRL, ctl(c[4:0], {5'h0, c[0], 2'h1}, 4'h0));
      src(c, 1'b1);
      rd(ADDR_STATUS, stat(c[0] ? r : r - 16'h1, 5'h08));
      src(c, 1'b0);
      rd(ADDR_STATUS, stat(r - 16'h1, 5'h08));
    end
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_STROBE, 32'h1);
    wr(ADDR_IRQ_CTRL, {27'h0, ln, 2'h3});
    wr(ADDR_EVT_MASK, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    pulse(0, int'(r) + 1);
    chk(upd, 32'h1);
    rd(ADDR_STATUS, stat(r, 5'h09));
    chk({24'h0, groupLines}, 32'h1 << ln);
    wr(ADDR_STROBE, 32'h2);
    pulse(0, int'(r) + 1);
    chk(upd, 32'h2);
    rd(ADDR_STATUS, stat(s, 5'h0f));
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_EVT_MASK, 32'h3);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_EVT_STATUS, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_CTRL, {27'h0, ln, 2'h1});
    chk({24'h0, groupLines}, 32'h0);
    wr(ADDR_STROBE, 32'hc);
    rd(ADDR_STATUS, stat(s, 5'h0c));
    wr(ADDR_CTRL, 32'h3);
    pulse(0, 1);
    rd(ADDR_STATUS, stat(s, 5'h1c));
    wr(ADDR_CTRL, 32'h1);
    pulse(0, 1);
    rd(ADDR_STATUS, stat(s - 16'h1, 5'h0c));
    // level gate on a function input: low pauses, then high runs
    wr(ADDR_CTRL, ctl(5'h0, 8'h11, g));
    pulse(0, 1);
    rd(ADDR_STATUS, stat(s - 16'h1, 5'h1c));
    src(int'(g) + 1, 1'b1);
    pulse(0, 1);
    rd(ADDR_STATUS, stat(s - 16'h2, 5'h0c));
    wr(ADDR_CTRL, ctl(5'h0, 8'h31, g));
    pulse(0, 1);
    rd(ADDR_STATUS, stat(s - 16'h2, 5'h1c));
    // toggle gate: gate off clears the toggle, each rising gate flips pause
    wr(ADDR_CTRL, ctl(5'h0, 8'h01, g));
    wr(ADDR_CTRL, ctl(5'h0, 8'h71, g));
    pulse(0, 1);
    rd(ADDR_STATUS, stat(s - 16'h3, 5'h0c));
    src(int'(g) + 1, 1'b0);
    pulse(0, 1);
    rd(ADDR_STATUS, stat(s - 16'h3, 5'h1c));
    wr(ADDR_CTRL, 32'h0);
    pulse(0, 1);
    rd(ADDR_STATUS, stat(s - 16'h3, 5'h04));
    chk(upd, 32'h2);
    // end of staging: idle register at maximal count, swap, disarm after terminal
    wr(ADDR_RELOAD_FIRST, 32'h0000ffff);
    wr(ADDR_STROBE, 32'h2);
    wr(ADDR_CTRL, 32'h1);
    pulse(0, int'(s) - 2);
    wr(ADDR_CTRL, 32'h0);
    chk(upd, 32'h3);
    rd(ADDR_STATUS, stat(16'hffff, 5'h01));
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule : tb_secondary_interval_timer
